// file: rtl/icw_pkg.sv
// constants and types for the identify capability word bank
package icw_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] ICW_OFS_CFG   = 8'h00;
    localparam logic [7:0] ICW_OFS_EN    = 8'h04;
    localparam logic [7:0] ICW_OFS_MODE  = 8'h08;
    localparam logic [7:0] ICW_OFS_W53   = 8'h10;
    localparam logic [7:0] ICW_OFS_W63   = 8'h14;
    localparam logic [7:0] ICW_OFS_W68   = 8'h18;
    localparam logic [7:0] ICW_OFS_W82   = 8'h20;
    localparam logic [7:0] ICW_OFS_W83   = 8'h24;
    localparam logic [7:0] ICW_OFS_W84   = 8'h28;
    localparam logic [7:0] ICW_OFS_W85   = 8'h2C;
    localparam logic [7:0] ICW_OFS_W86   = 8'h30;
    localparam logic [7:0] ICW_OFS_W87   = 8'h34;
    localparam logic [7:0] ICW_OFS_W88   = 8'h38;
    localparam logic [7:0] ICW_OFS_W93   = 8'h40;

    // cfg register field positions
    localparam int ICW_CFG_SEC     = 0;
    localparam int ICW_CFG_WC      = 1;
    localparam int ICW_CFG_LA      = 2;
    localparam int ICW_CFG_APM     = 3;
    localparam int ICW_CFG_PIO3    = 4;
    localparam int ICW_CFG_PIO4    = 5;
    localparam int ICW_CFG_NATIVE  = 6;
    localparam int ICW_CFG_UDMA_LO = 8;
    localparam int ICW_CFG_MDMA_LO = 12;

    // en register field positions match the cfg feature bits
    localparam int ICW_EN_SEC = 0;
    localparam int ICW_EN_WC  = 1;
    localparam int ICW_EN_LA  = 2;
    localparam int ICW_EN_APM = 3;

    // mode register field positions
    localparam int ICW_MODE_KIND_LO = 0;
    localparam int ICW_MODE_NUM_LO  = 4;

    // reset values: all features present, pio4, udma 0..4, mdma 0..2
    localparam logic [3:0] ICW_RST_SUP   = 4'hF;
    localparam logic [3:0] ICW_RST_EN    = 4'h0;
    localparam logic       ICW_RST_PIO3  = 1'b1;
    localparam logic       ICW_RST_PIO4  = 1'b1;
    localparam logic       ICW_RST_NAT   = 1'b1;
    localparam logic [2:0] ICW_RST_UDMA  = 3'h5;
    localparam logic [1:0] ICW_RST_MDMA  = 2'h3;

    // fastest pio cycle times with flow control, in ns
    localparam logic [15:0] ICW_PIO4_CYC_NS = 16'h0078;
    localparam logic [15:0] ICW_PIO3_CYC_NS = 16'h00B4;

    // fixed patterns of the supported/enabled words
    localparam logic [15:0] ICW_W82_FIXED = 16'h7008;
    localparam logic [15:0] ICW_VALID_TAG = 16'h4000;
    localparam logic [15:0] ICW_W93_FIXED = 16'h4000;
    localparam int          ICW_UDMA_BITS = 7;
    localparam int          ICW_SEL_LO    = 8;
    localparam int          ICW_W93_CBL   = 13;
    localparam logic [2:0]  ICW_MDMA_MAX  = 3'h2;

    // transfer mode kinds
    typedef enum logic [1:0] {
        ICW_KIND_NONE = 2'h0,
        ICW_KIND_MDMA = 2'h1,
        ICW_KIND_UDMA = 2'h2
    } icw_kind_e;

    // apb answer sequencer, one-hot
    typedef enum logic [1:0] {
        ICW_ST_IDLE = 2'b01,
        ICW_ST_RESP = 2'b10
    } icw_state_e;

endpackage

// file: rtl/icw_regs.sv
// apb register bank that builds identify words 53, 63, 68, 82-88, 93
// Summary of operation
// - word 68 gives fastest iordy pio cycle
// - word 68 zero without pio 3 or 4
// - words 83, 84: bit14 one, bit15 zero
// - reserved bits of 83, 84 read zero
// - word 82 unsupported feature bits read zero
// - word 82 bits 3,12,13,14 read one
// - word 82 bits 1,5,6 show support
// - word 83 bits 0-2,4 zero, bit3 apm
// - word 87 reads valid tag only
// - word 85 fixed pattern like word 82
// - word 85 bits 1,5,6 show enables
// - word 86 zero except apm enabled bit3
// - only one dma mode selected at once
// - udma supported bits are cumulative
// - word 88 zero outside native taskfile mode
// - word 93 low bits change only in reset
// - word 93 bit15 zero, bit14 one
// - word 93 bit13 shows sensed cable id
// - word 93 device 1 result bits
// - word 93 device 0 result bits
// - word 53 bit1 marks words 64-70 valid
// - word 63 selects at most one mode
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module icw_regs
    import icw_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hw_reset_active,
    input  wire logic        cable_id_high,
    input  wire logic        is_device1,
    input  wire logic        pdiag_seen,
    input  wire logic        dasp_seen,
    input  wire logic        diag_passed,
    input  wire logic        responds_dev1,
    input  wire logic [1:0]  devnum_method
);

    typedef struct packed {
        icw_state_e  st;
        logic [3:0]  sup;       // sec, wc, la, apm supported
        logic [3:0]  en;        // sec, wc, la, apm enabled
        logic        pio3;
        logic        pio4;
        logic        native;
        logic [2:0]  udma_cnt;  // number of udma modes supported
        logic [1:0]  mdma_cnt;  // number of mdma modes supported
        icw_kind_e   kind;
        logic [2:0]  num;
        logic [13:0] w93_cap;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } icw_regs_s;

    icw_regs_s s_r;
    icw_regs_s s_nxt;

    logic [15:0] w53;
    logic [15:0] w63;
    logic [15:0] w68;
    logic [15:0] w82;
    logic [15:0] w83;
    logic [15:0] w84;
    logic [15:0] w85;
    logic [15:0] w86;
    logic [15:0] w87;
    logic [15:0] w88;
    logic [15:0] w93;
    logic [6:0]  udma_sup_bits;
    logic [7:0]  udma_sel_bits;
    logic [7:0]  mdma_sel_bits;
    logic [2:0]  mdma_sup_bits;
    logic        udma_ok;
    // bus decode helpers
    logic [15:0] rd_word;   // word at paddr, zero when unmapped
    logic        addr_hit;  // paddr names a register
    logic        addr_rw;   // paddr names a writable register
    logic        mode_bad;  // mode write the drive cannot run

    // udma supported bits are a thermometer of the support count
    genvar gi;
    generate
        for (gi = 0; gi < ICW_UDMA_BITS; gi++)
        begin : g_udma_sup
            assign udma_sup_bits[gi] = (3'(gi) < s_r.udma_cnt);
        end
        for (gi = 0; gi < 3; gi++)
        begin : g_mdma_sup
            assign mdma_sup_bits[gi] = (2'(gi) < s_r.mdma_cnt);
        end
    endgenerate

    // udma only reported in native mode with some udma support
    assign udma_ok = s_r.native && (s_r.udma_cnt != 3'h0);

    // selected-mode bit fields, one-hot from a single kind register
    always_comb
    begin
        udma_sel_bits = 8'h00;
        mdma_sel_bits = 8'h00;
        if (s_r.kind == ICW_KIND_UDMA)
            udma_sel_bits[s_r.num] = 1'b1;
        if (s_r.kind == ICW_KIND_MDMA)
            mdma_sel_bits[s_r.num] = 1'b1;
    end

    // word 53: timing words always valid, bit 2 flags word 88
    always_comb
    begin
        w53 = {13'h0000, udma_ok, 1'b1, 1'b0};
    end

    // word 63: selected mode in the high byte, support in the low
    always_comb
    begin
        w63 = {mdma_sel_bits, 5'h00, mdma_sup_bits};
    end

    // word 68: pio4 wins over pio3 as the faster mode
    always_comb
    begin
        if (s_r.pio4)
            w68 = ICW_PIO4_CYC_NS;
        else if (s_r.pio3)
            w68 = ICW_PIO3_CYC_NS;
        else
            w68 = 16'h0000;
    end

    // words 82-84: fixed pattern plus the support flags
    always_comb
    begin
        w82 = ICW_W82_FIXED;
        w82[1] = s_r.sup[ICW_CFG_SEC];
        w82[5] = s_r.sup[ICW_CFG_WC];
        w82[6] = s_r.sup[ICW_CFG_LA];
        w83 = ICW_VALID_TAG;
        w83[3] = s_r.sup[ICW_CFG_APM];
        w84 = ICW_VALID_TAG;
    end

    // words 85-87: enable flags in the support places; 86 lacks the valid tag
    always_comb
    begin
        w85 = ICW_W82_FIXED;
        w85[1] = s_r.en[ICW_EN_SEC];
        w85[5] = s_r.en[ICW_EN_WC];
        w85[6] = s_r.en[ICW_EN_LA];
        w86 = 16'h0000;
        w86[3] = s_r.en[ICW_EN_APM];
        w87 = ICW_VALID_TAG;
    end

    // word 88: a host must never see udma outside native mode
    always_comb
    begin
        if (udma_ok)
            w88 = {1'b0, udma_sel_bits[6:0], 1'b0, udma_sup_bits};
        else
            w88 = 16'h0000;
    end

    // word 93: fixed top bits over the captured reset results
    always_comb
    begin
        w93 = ICW_W93_FIXED | {2'b00, s_r.w93_cap};
    end

    // read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        rd_word  = 16'h0000;
        addr_hit = 1'b1;
        addr_rw  = 1'b0;
        case (paddr)
            ICW_OFS_CFG:
            begin
                // same packing as the cfg write layout
                rd_word = {2'b00, s_r.mdma_cnt, 1'b0, s_r.udma_cnt, 1'b0,
                           s_r.native, s_r.pio4, s_r.pio3, s_r.sup};
                addr_rw = 1'b1;
            end
            ICW_OFS_EN:
            begin
                // enables already masked by support
                rd_word = {12'h000, s_r.en};
                addr_rw = 1'b1;
            end
            ICW_OFS_MODE:
            begin
                // kind and number as held; kind clears when a cfg write drops support
                rd_word = {9'h000, s_r.num, 2'b00, s_r.kind};
                addr_rw = 1'b1;
            end
            ICW_OFS_W53: rd_word = w53;
            ICW_OFS_W63: rd_word = w63;
            ICW_OFS_W68: rd_word = w68;
            ICW_OFS_W82: rd_word = w82;
            ICW_OFS_W83: rd_word = w83;
            ICW_OFS_W84: rd_word = w84;
            ICW_OFS_W85: rd_word = w85;
            ICW_OFS_W86: rd_word = w86;
            ICW_OFS_W87: rd_word = w87;
            ICW_OFS_W88: rd_word = w88;
            ICW_OFS_W93: rd_word = w93;
            default:     addr_hit = 1'b0;
        endcase
    end

    // mode check; kind 3 and unsupported numbers are refused
    always_comb
    begin
        mode_bad = 1'b0;
        case (pwdata[ICW_MODE_KIND_LO +: 2])
            ICW_KIND_NONE:
                mode_bad = 1'b0;
            ICW_KIND_MDMA:
                mode_bad = pwdata[ICW_MODE_NUM_LO +: 3] > ICW_MDMA_MAX ||
                           pwdata[ICW_MODE_NUM_LO +: 3] >=
                           3'(s_r.mdma_cnt);
            ICW_KIND_UDMA:
                mode_bad = !udma_ok ||
                           pwdata[ICW_MODE_NUM_LO +: 3] >= s_r.udma_cnt;
            default:
                mode_bad = 1'b1;
        endcase
    end

    // next state: apb sequencing, register writes, reset capture
    always_comb
    begin
        logic        wr_done;
        logic [2:0]  wnum;
        icw_kind_e   wkind;
        logic [2:0]  ucnt;
        logic [1:0]  mcnt;
        s_nxt    = s_r;
        wr_done  = 1'b0;
        wnum     = pwdata[ICW_MODE_NUM_LO +: 3];
        wkind    = icw_kind_e'(pwdata[ICW_MODE_KIND_LO +: 2]);
        ucnt     = pwdata[ICW_CFG_UDMA_LO +: 3];
        mcnt     = pwdata[ICW_CFG_MDMA_LO +: 2];
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        case (s_r.st)
            ICW_ST_IDLE:
            begin
                // setup phase seen: answer ready for the access edge
                if (psel && !penable)
                begin
                    s_nxt.st     = ICW_ST_RESP;
                    s_nxt.pready = 1'b1;
                    // identify words in the low half, upper half zero
                    s_nxt.prdata = {16'h0000, rd_word};
                    // unmapped offset, or write to a read-only word
                    s_nxt.pslverr = !addr_hit || (pwrite && !addr_rw);
                    // refuse a mode the drive cannot run
                    if (pwrite && paddr == ICW_OFS_MODE)
                        s_nxt.pslverr = mode_bad;
                end
            end
            ICW_ST_RESP:
            begin
                // write lands only on the completing access edge
                s_nxt.st = ICW_ST_IDLE;
                wr_done  = psel && penable && pwrite && !s_r.pslverr;
            end
            default:
                s_nxt.st = ICW_ST_IDLE;
        endcase
        if (wr_done)
        begin
            case (paddr)
                ICW_OFS_CFG:
                begin
                    s_nxt.sup      = pwdata[ICW_CFG_SEC +: 4];
                    s_nxt.pio3     = pwdata[ICW_CFG_PIO3];
                    s_nxt.pio4     = pwdata[ICW_CFG_PIO4];
                    s_nxt.native   = pwdata[ICW_CFG_NATIVE];
                    s_nxt.udma_cnt = ucnt;
                    s_nxt.mdma_cnt = mcnt;
                    // enables cannot outlive their feature
                    s_nxt.en       = s_r.en & pwdata[ICW_CFG_SEC +: 4];
                    // drop a selection that is no longer supported
                    if ((s_r.kind == ICW_KIND_UDMA && (s_r.num >= ucnt
                        || !pwdata[ICW_CFG_NATIVE])) ||
                        (s_r.kind == ICW_KIND_MDMA && s_r.num >= 3'(mcnt)))
                        s_nxt.kind = ICW_KIND_NONE;
                end
                ICW_OFS_EN:
                    s_nxt.en = pwdata[ICW_EN_SEC +: 4] & s_r.sup;
                ICW_OFS_MODE:
                begin
                    s_nxt.kind = wkind;
                    s_nxt.num  = wnum;
                end
                default:
                    s_nxt.kind = s_r.kind;
            endcase
        end
        if (hw_reset_active)
        begin
            s_nxt.w93_cap = 14'h0000;
            s_nxt.w93_cap[ICW_W93_CBL] = cable_id_high;
            if (is_device1)
                s_nxt.w93_cap[12:8] = {1'b0, pdiag_seen, devnum_method,
                                       1'b1};
            else
                s_nxt.w93_cap[7:0] = {1'b0, responds_dev1, dasp_seen,
                    pdiag_seen, diag_passed, devnum_method, 1'b1};
        end
    end

    // state register; synchronous reset to constants only
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_r.st       <= ICW_ST_IDLE;
            s_r.sup      <= ICW_RST_SUP;
            s_r.en       <= ICW_RST_EN;
            s_r.pio3     <= ICW_RST_PIO3;
            s_r.pio4     <= ICW_RST_PIO4;
            s_r.native   <= ICW_RST_NAT;
            s_r.udma_cnt <= ICW_RST_UDMA;
            s_r.mdma_cnt <= ICW_RST_MDMA;
            s_r.kind     <= ICW_KIND_NONE;
            s_r.num      <= 3'h0;
            s_r.w93_cap  <= 14'h0000;
            s_r.prdata   <= 32'h0000_0000;
            s_r.pready   <= 1'b0;
            s_r.pslverr  <= 1'b0;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from the state flops
    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;

endmodule // icw_regs

// file: bench/icw_chk.sv
// concurrent checks on the apb ports of the identify word bank
`timescale 1ns/1ps
module icw_chk
    import icw_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        hw_reset_active,
    input wire logic        cable_id_high,
    input wire logic        is_device1,
    input wire logic        pdiag_seen,
    input wire logic        dasp_seen,
    input wire logic        diag_passed,
    input wire logic        responds_dev1,
    input wire logic [1:0]  devnum_method
);
    // completed read, shared by the word checks
    logic rd_ok;
    assign rd_ok = psel && penable && pready && !pwrite;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("no answer right after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("slave error outside an answer");
    unmapped_a: assert property (psel && !penable && paddr == 8'h0C
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    ro_write_a: assert property (psel && !penable && pwrite
        && paddr >= ICW_OFS_W53 |=> pslverr)
        else $error("write to identify word accepted");
    w82_fixed_a: assert property (rd_ok && paddr == ICW_OFS_W82
        |-> (prdata[15:0] & 16'h779D) == 16'h7008)
        else $error("word 82 fixed bits wrong");
    w85_fixed_a: assert property (rd_ok && paddr == ICW_OFS_W85
        |-> (prdata[15:0] & 16'h779D) == 16'h7008)
        else $error("word 85 fixed bits wrong");
    valid_tag_a: assert property (rd_ok && (paddr == ICW_OFS_W83
        || paddr == ICW_OFS_W84 || paddr == ICW_OFS_W87)
        |-> prdata[15:14] == 2'b01)
        else $error("valid tag missing");
    w86_res_a: assert property (rd_ok && paddr == ICW_OFS_W86
        |-> prdata[15:4] == 12'h0 && prdata[2:0] == 3'h0)
        else $error("word 86 reserved bits set");
    w88_shape_a: assert property (rd_ok && paddr == ICW_OFS_W88
        |-> !prdata[15] && !prdata[7] && $onehot0(prdata[14:8])
        && (prdata[6:0] & (prdata[6:0] + 7'h1)) == 7'h0)
        else $error("word 88 malformed");
    w93_fixed_a: assert property (rd_ok && paddr == ICW_OFS_W93
        |-> prdata[15:14] == 2'b01)
        else $error("word 93 top bits wrong");
    w53_valid_a: assert property (rd_ok && paddr == ICW_OFS_W53
        |-> prdata[1])
        else $error("word 53 timing words not valid");
    res_zero_a: assert property (rd_ok && (paddr == ICW_OFS_W84
        || paddr == ICW_OFS_W87) |-> prdata[13:0] == 14'h0)
        else $error("reserved bits of word 84 or 87 set");
    dev_half_a: assert property (rd_ok && paddr == ICW_OFS_W93
        |-> (is_device1 ? prdata[7:0] == 8'h0 : prdata[12:8] == 5'h0))
        else $error("word 93 other device half not clear");
endmodule // icw_chk

// file: bench/icw_host_model.sv
// apb host model that fetches identify words from the bank
`timescale 1ns/1ps
module icw_host_model
(
    input  wire logic        sys_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic feat_ok; // last word carried feature information

    // bus idle from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        feat_ok = 1'b0;
    end

    // one transfer; request held until pready seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        // all zero or all one means no feature info
        feat_ok = !(prdata[15:0] inside {16'h0000, 16'hFFFF});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // icw_host_model

// file: bench/identify_capability_words_bench.sv
// self-checking bench for the identify word bank
`timescale 1ns/1ps
module identify_capability_words_bench
    import icw_pkg::*;
;
    logic sys_clk = 1'b0, srst = 1'b1, hw = 1'b0, cbl = 1'b0, dev1 = 1'b0;
    logic pdg = 1'b0, dsp = 1'b0, dgp = 1'b0, rsp = 1'b0;
    logic [1:0]  mth = 2'b00;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          num_errors = 0, check_count = 0;

    // 10 mhz clock
    always #50 sys_clk = ~sys_clk;

    icw_regs icw_regs_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_reset_active(hw), .cable_id_high(cbl),
        .is_device1(dev1), .pdiag_seen(pdg), .dasp_seen(dsp),
        .diag_passed(dgp), .responds_dev1(rsp), .devnum_method(mth));
    icw_host_model icw_host_model_inst (.sys_clk(sys_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // compare error flag and data together
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, input logic [32:0] exp);
        logic [31:0] d;
        logic        e;
        icw_host_model_inst.xfer(wr, a, wd, d, e);
        cmp(wr ? {e, 32'h0} : {e, d}, exp);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, {1'b0, exp});
    endtask

    task automatic wchk(input logic [7:0] a, input logic [31:0] wd);
        acc(1'b1, a, wd, 33'h0);
    endtask

    // words straight after reset
    task automatic t_reset_words();
        logic [31:0] d;
        logic        e;
        icw_host_model_inst.xfer(1'b0, ICW_OFS_W53, 32'h0, d, e);
        cmp({e, d & 32'hFFFFFFFE}, 33'h6);
        rchk(ICW_OFS_CFG, 32'h357F);
        rchk(ICW_OFS_W68, 32'h0078);
        rchk(ICW_OFS_W82, 32'h706A);
        cmp({32'h0, icw_host_model_inst.feat_ok}, 33'h1);
        rchk(ICW_OFS_W83, 32'h4008);
        rchk(ICW_OFS_W84, 32'h4000);
        rchk(ICW_OFS_W85, 32'h7008);
        rchk(ICW_OFS_W86, 32'h0000);
        rchk(ICW_OFS_W87, 32'h4000);
        rchk(ICW_OFS_W88, 32'h001F);
        rchk(ICW_OFS_W63, 32'h0007);
        rchk(ICW_OFS_W93, 32'h4000);
    endtask

    // enables, support drop and pio cycle time
    task automatic t_features();
        wchk(ICW_OFS_EN, 32'hF);
        rchk(ICW_OFS_W85, 32'h706A);
        rchk(ICW_OFS_W86, 32'h0008);
        wchk(ICW_OFS_CFG, 32'h3570);
        rchk(ICW_OFS_W82, 32'h7008);
        rchk(ICW_OFS_W83, 32'h4000);
        rchk(ICW_OFS_W85, 32'h7008);
        rchk(ICW_OFS_W86, 32'h0000);
        wchk(ICW_OFS_CFG, 32'h355F);
        rchk(ICW_OFS_W68, 32'h00B4);
        wchk(ICW_OFS_CFG, 32'h354F);
        rchk(ICW_OFS_W68, 32'h0000);
        wchk(ICW_OFS_CFG, 32'h357F);
    endtask

    // mode selection, refusals and native mode
    task automatic t_modes();
        wchk(ICW_OFS_MODE, 32'h22);
        rchk(ICW_OFS_W88, 32'h041F);
        rchk(ICW_OFS_W63, 32'h0007);
        wchk(ICW_OFS_MODE, 32'h11);
        rchk(ICW_OFS_W63, 32'h0207);
        rchk(ICW_OFS_W88, 32'h001F);
        wchk(ICW_OFS_MODE, 32'h42);
        acc(1'b1, ICW_OFS_MODE, 32'h52, {1'b1, 32'h0});
        acc(1'b1, ICW_OFS_MODE, 32'h31, {1'b1, 32'h0});
        rchk(ICW_OFS_W88, 32'h101F);
        wchk(ICW_OFS_CFG, 32'h377F);
        rchk(ICW_OFS_W88, 32'h107F);
        wchk(ICW_OFS_CFG, 32'h353F);
        rchk(ICW_OFS_W88, 32'h0000);
        wchk(ICW_OFS_CFG, 32'h307F);
        rchk(ICW_OFS_W88, 32'h0000);
        acc(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
        acc(1'b0, 8'h44, 32'h0, {1'b1, 32'h0});
        acc(1'b1, ICW_OFS_W68, 32'h1, {1'b1, 32'h0});
        acc(1'b1, ICW_OFS_MODE, 32'h03, {1'b1, 32'h0});
        acc(1'b1, ICW_OFS_MODE, 32'h02, {1'b1, 32'h0});
        wchk(ICW_OFS_MODE, 32'h21);
        rchk(ICW_OFS_MODE, 32'h21);
        rchk(ICW_OFS_W63, 32'h0407);
        wchk(ICW_OFS_CFG, 32'h107F);
        rchk(ICW_OFS_W63, 32'h0001);
        rchk(ICW_OFS_MODE, 32'h20);
        wchk(ICW_OFS_MODE, 32'h00);
    endtask

    // capture during hardware reset, hold after it
    task automatic t_word93();
        @(posedge sys_clk);
        {hw, cbl, pdg, dsp, dgp, rsp, mth} <= {6'h3F, 2'b01};
        repeat (3) @(posedge sys_clk);
        hw <= 1'b0;
        @(posedge sys_clk);
        {cbl, pdg, mth} <= {2'b00, 2'b11};
        rchk(ICW_OFS_W93, 32'h607B);
        @(posedge sys_clk);
        {hw, dev1, pdg, mth} <= {3'b111, 2'b10};
        repeat (3) @(posedge sys_clk);
        hw <= 1'b0;
        rchk(ICW_OFS_W93, 32'h4D00);
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset_words();
        t_features();
        t_modes();
        t_word93();
        stop_test();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
endmodule // identify_capability_words_bench

bind icw_regs icw_chk icw_chk_inst (.sys_clk(sys_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_reset_active(hw_reset_active), .cable_id_high(cable_id_high),
    .is_device1(is_device1), .pdiag_seen(pdiag_seen),
    .dasp_seen(dasp_seen), .diag_passed(diag_passed),
    .responds_dev1(responds_dev1), .devnum_method(devnum_method));
